// ==== timer_unit_defines.vh ====
// Offsets, field positions, reset values and timing counts of the timer unit
`ifndef TIMER_UNIT_DEFINES_VH
`define TIMER_UNIT_DEFINES_VH

`define ADDR_TIMER1_CONTROL 6'h0C
`define ADDR_POWER_CONTROL 6'h0E
`define ADDR_IRQ_ENABLE_MASK 6'h0F

`define TIMER1_CONTROL_RUN_BIT 2
`define TIMER1_CONTROL_PRESCALE_HI 1
`define TIMER1_CONTROL_PRESCALE_LO 0
`define TIMER1_CONTROL_RESET 8'h00
`define TIMER1_CONTROL_WR_MASK 8'h07

`define POWER_CONTROL_WDT_ENABLE_BIT 5
`define POWER_CONTROL_RESET 8'h21
`define POWER_CONTROL_WR_MASK 8'hE9
`define POWER_CONTROL_READ_ONES 8'h10

`define INTERRUPT_ENABLE_MASK_TIMER0_BIT 0
`define INTERRUPT_ENABLE_MASK_TIMER1_BIT 3
`define INTERRUPT_ENABLE_MASK_RESET 8'h00

`define OPTION_ASSIGN_BIT 3
`define OPTION_RATIO_HI 2
`define OPTION_RATIO_LO 0
`define OPTION_RESET 8'hBF
`define OPTION_WR_MASK 8'hBF

`define PRESCALER_RESET 8'hFF
`define PRESCALER_CLEAR 8'h00

`define CLKS_PER_INSTR 4
`define TIMER0_WRITE_INHIBIT 2

`define WDT_TIMEOUT_MS 18
`define WDT_RC_KHZ 256
`define WDT_TIMEOUT_TICKS (`WDT_TIMEOUT_MS * `WDT_RC_KHZ)

`endif

// ==== shared_prescaler.v ====
// Eight-bit down-counting prescaler shared by Timer0 and the watchdog
`timescale 1ns/1ns
`include "timer_unit_defines.vh"

module shared_prescaler (
    input wire clk,
    input wire sys_rst,
    input wire clear,
    input wire step,
    input wire [7:0] ratio_mask,
    output wire tick_out
);
    reg [7:0] count;
    wire [7:0] next_count;

    assign next_count = count - 8'h01;
    // Divided event when masked low bits of the decremented value reach zero
    assign tick_out = step && !clear && ((next_count & ratio_mask) == 8'h00);

    always @(posedge clk) begin
        if (sys_rst) begin
            count <= `PRESCALER_RESET; // RQ18
        end else if (clear) begin
            count <= `PRESCALER_CLEAR;
        end else if (step) begin
            count <= next_count; // RQ16
        end
    end
endmodule

// ==== timer_wdt_prescaler_unit.v ====
// Timer0, Timer1, watchdog and shared prescaler with their control registers
//
// What this block does
// (RQ1) Timer1 prescale code 00/01/10/11 divides by 1, 4, 8, 16.
// (RQ2) Timer1 counts the instruction clock, one quarter of clk, no external clock.
// (RQ3) With its run bit set, timer1 steps on each prescaled clock.
// (RQ4) With run bit clear timer1 holds and never sets its flag.
// (RQ5) Timer1 counts from zero to period, then wraps to zero and sets its flag.
// (RQ6) Timer1 prescaler clears on count write, control write and reset.
// (RQ7) Mask register holds one enable per interrupt source, one enables.
// (RQ8) Timer0 counts once per instruction cycle without the prescaler.
// (RQ9) A Timer0 write blocks counting for the next two instruction cycles.
// (RQ10) Watchdog runs from its own oscillator, also while asleep.
// (RQ11) Watchdog time-out resets the device and clears the time-out status.
// (RQ12) Watchdog enable bit in power control turns the watchdog on and off.
// (RQ13) Watchdog time-out is 18 ms, stretched up to 128 times by the prescaler.
// (RQ14) Watchdog clear instruction clears watchdog and its assigned prescaler.
// (RQ15) Sleep instruction clears watchdog and its assigned prescaler.
// (RQ16) One 8-bit down prescaler serves Timer0 or watchdog, ratio from option bits.
// (RQ17) With prescaler on Timer0, any Timer0 write clears the prescaler.
// (RQ18) Prescaler is hidden from software and loads all ones on reset.
// (RQ19) Software clears watchdog or Timer0 before moving the prescaler.
// (RQ20) Ratio codes give Timer0 1:2 to 1:256 and watchdog 1:1 to 1:128.
// (RQ21) Assign bit one gives the prescaler to watchdog, zero to Timer0.
// (RQ22) Timer0 overflow sets its flag, which stays until software clears it.
// (RQ23) Each timer requests an interrupt only with flag and enable both set.
`timescale 1ns/1ns
`include "timer_unit_defines.vh"

module timer_wdt_prescaler_unit #(
    parameter WDT_TICKS = `WDT_TIMEOUT_TICKS
) (
    input wire clk,
    input wire sys_rst,
    input wire [5:0] ctrl_addr,
    input wire ctrl_wr,
    input wire [7:0] ctrl_wdata,
    input wire option_wr,
    input wire [7:0] option_wdata,
    input wire [7:0] file_wdata,
    input wire timer0_wr,
    input wire timer1_wr,
    input wire period_wr,
    input wire timer0_flag_clr,
    input wire timer1_flag_clr,
    input wire watchdog_clear_instr,
    input wire sleep_instr,
    input wire wdt_osc,
    output reg [7:0] ctrl_rdata,
    output reg [7:0] option_value,
    output reg [7:0] timer0_count,
    output reg [7:0] timer1_count,
    output reg [7:0] timer1_period,
    output reg timer0_overflow_flag,
    output reg timer1_match_flag,
    output reg timer0_irq,
    output reg timer1_irq,
    output reg watchdog_reset,
    output reg timeout_status
);
    // Full-width constants first, then cut to the counter widths on purpose
    localparam [31:0] INSTR_LAST_FULL = `CLKS_PER_INSTR - 1;
    localparam [31:0] INHIBIT_FULL = `TIMER0_WRITE_INHIBIT;
    localparam [31:0] WDT_LAST_FULL = WDT_TICKS - 1;
    localparam [1:0] INSTR_LAST = INSTR_LAST_FULL[1:0];
    localparam [1:0] INHIBIT_CYCLES = INHIBIT_FULL[1:0];
    localparam [15:0] WDT_LAST = WDT_LAST_FULL[15:0];

    // Low-bit mask of the down counter for the selected ratio
    function [7:0] ratio_mask;
        input [2:0] code;
        input for_wdt;
        begin
            if (for_wdt) begin
                ratio_mask = (8'h01 << code) - 8'h01; // RQ20
            end else begin
                ratio_mask = (8'h02 << code) - 8'h01; // RQ20
            end
        end
    endfunction

    reg [7:0] timer1_control;
    reg [7:0] power_control;
    reg [7:0] interrupt_enable_mask;
    reg [1:0] instr_phase;
    reg instr_tick;
    reg [1:0] t0_inhibit;
    reg [3:0] t1_prescale;
    reg [3:0] t1_prescale_last;
    reg osc_meta;
    reg osc_sync;
    reg osc_prev;
    reg [15:0] wdt_count;
    reg [7:0] next_rdata;

    wire prescaler_assign;
    wire [2:0] prescaler_ratio;
    wire timer1_run;
    wire [1:0] timer1_prescale_sel;
    wire watchdog_enable;
    wire ctrl_wr_timer1_control;
    wire rc_tick;
    wire wdt_base;
    wire wdt_restart;
    wire pre_step;
    wire pre_clear;
    wire pre_tick;
    wire t0_source;
    wire t0_step;
    wire t0_overflow;
    wire t1_step;
    wire t1_match;
    wire wdt_timeout;

    assign prescaler_assign = option_value[`OPTION_ASSIGN_BIT];
    assign prescaler_ratio = option_value[`OPTION_RATIO_HI:`OPTION_RATIO_LO];
    assign timer1_run = timer1_control[`TIMER1_CONTROL_RUN_BIT];
    assign timer1_prescale_sel = timer1_control[`TIMER1_CONTROL_PRESCALE_HI:`TIMER1_CONTROL_PRESCALE_LO];
    assign watchdog_enable = power_control[`POWER_CONTROL_WDT_ENABLE_BIT];
    assign ctrl_wr_timer1_control = ctrl_wr && (ctrl_addr == `ADDR_TIMER1_CONTROL);

    // Instruction clock: one enable pulse every four clk cycles
    always @(posedge clk) begin
        if (sys_rst) begin
            instr_phase <= 2'h0;
            instr_tick <= 1'b0;
        end else begin
            instr_phase <= instr_phase + 2'h1;
            instr_tick <= (instr_phase == INSTR_LAST);
        end
    end

    // Control registers on the byte-wide access port; unmapped addresses are ignored
    always @(posedge clk) begin
        if (sys_rst) begin
            timer1_control <= `TIMER1_CONTROL_RESET;
            power_control <= `POWER_CONTROL_RESET;
            interrupt_enable_mask <= `INTERRUPT_ENABLE_MASK_RESET;
        end else if (ctrl_wr) begin
            case (ctrl_addr)
                `ADDR_TIMER1_CONTROL: begin
                    timer1_control <= ctrl_wdata & `TIMER1_CONTROL_WR_MASK;
                end
                `ADDR_POWER_CONTROL: begin
                    power_control <= ctrl_wdata & `POWER_CONTROL_WR_MASK; // RQ12
                end
                `ADDR_IRQ_ENABLE_MASK: begin
                    interrupt_enable_mask <= ctrl_wdata; // RQ7
                end
                default: begin
                end
            endcase
        end
    end

    always @* begin
        case (ctrl_addr)
            `ADDR_TIMER1_CONTROL: next_rdata = timer1_control;
            `ADDR_POWER_CONTROL: next_rdata = power_control | `POWER_CONTROL_READ_ONES;
            `ADDR_IRQ_ENABLE_MASK: next_rdata = interrupt_enable_mask;
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl_rdata <= 8'h00;
        end else begin
            ctrl_rdata <= next_rdata;
        end
    end

    // Option register, loaded by the option instruction; the global enable bit lives elsewhere
    always @(posedge clk) begin
        if (sys_rst) begin
            option_value <= `OPTION_RESET;
        end else if (option_wr) begin
            option_value <= option_wdata & `OPTION_WR_MASK;
        end
    end

    // Watchdog oscillator pin: two-stage synchroniser, then edge detect
    always @(posedge clk) begin
        if (sys_rst) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= wdt_osc;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign rc_tick = osc_sync && !osc_prev; // RQ10

    // Watchdog base counter; clk is assumed alive in sleep so the RC edges still count
    assign wdt_restart = watchdog_clear_instr || sleep_instr; // RQ14 RQ15
    assign wdt_base = watchdog_enable && rc_tick && !wdt_restart && (wdt_count == WDT_LAST); // RQ13

    always @(posedge clk) begin
        if (sys_rst) begin
            wdt_count <= 16'h0000;
        end else if (wdt_restart || !watchdog_enable) begin
            wdt_count <= 16'h0000; // RQ12
        end else if (rc_tick) begin
            if (wdt_count == WDT_LAST) begin
                wdt_count <= 16'h0000;
            end else begin
                wdt_count <= wdt_count + 16'h0001;
            end
        end
    end

    // Prescaler user and clear source follow the assign bit
    assign pre_step = prescaler_assign ? wdt_base : instr_tick; // RQ21
    assign pre_clear = prescaler_assign ? wdt_restart : timer0_wr; // RQ14 RQ15 RQ17

    shared_prescaler u_prescaler (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(pre_clear),
        .step(pre_step),
        .ratio_mask(ratio_mask(prescaler_ratio, prescaler_assign)),
        .tick_out(pre_tick)
    );

    assign wdt_timeout = prescaler_assign ? pre_tick : wdt_base; // RQ13 RQ16

    // Time-out holds the reset request until the device reset arrives
    always @(posedge clk) begin
        if (sys_rst) begin
            watchdog_reset <= 1'b0;
            timeout_status <= !watchdog_reset; // RQ11
        end else if (wdt_timeout) begin
            watchdog_reset <= 1'b1; // RQ11
            timeout_status <= 1'b0; // RQ11
        end else if (wdt_restart) begin
            timeout_status <= 1'b1;
        end
    end

    // Timer0
    assign t0_source = prescaler_assign ? instr_tick : pre_tick; // RQ8 RQ16
    assign t0_step = t0_source && (t0_inhibit == 2'h0) && !timer0_wr; // RQ9
    assign t0_overflow = t0_step && (timer0_count == 8'hFF);

    always @(posedge clk) begin
        if (sys_rst) begin
            timer0_count <= 8'h00;
            t0_inhibit <= 2'h0;
        end else if (timer0_wr) begin
            timer0_count <= file_wdata;
            t0_inhibit <= INHIBIT_CYCLES; // RQ9
        end else begin
            if (t0_step) begin
                timer0_count <= timer0_count + 8'h01; // RQ8
            end
            if (instr_tick && (t0_inhibit != 2'h0)) begin
                t0_inhibit <= t0_inhibit - 2'h1;
            end
        end
    end

    // Set wins over a clear in the same cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            timer0_overflow_flag <= 1'b0;
        end else if (t0_overflow) begin
            timer0_overflow_flag <= 1'b1; // RQ22
        end else if (timer0_flag_clr) begin
            timer0_overflow_flag <= 1'b0;
        end
    end

    // Timer1 prescaler: terminal value decoded from the select field
    always @* begin
        case (timer1_prescale_sel)
            2'b00: t1_prescale_last = 4'h0;
            2'b01: t1_prescale_last = 4'h3;
            2'b10: t1_prescale_last = 4'h7;
            2'b11: t1_prescale_last = 4'hF;
            default: t1_prescale_last = 4'h0;
        endcase
    end

    assign t1_step = instr_tick && timer1_run && (t1_prescale == t1_prescale_last)
        && !timer1_wr && !ctrl_wr_timer1_control; // RQ1 RQ2 RQ3 RQ4
    assign t1_match = t1_step && (timer1_count == timer1_period); // RQ5

    always @(posedge clk) begin
        if (sys_rst || timer1_wr || ctrl_wr_timer1_control) begin
            t1_prescale <= 4'h0; // RQ6
        end else if (instr_tick && timer1_run) begin
            if (t1_prescale == t1_prescale_last) begin
                t1_prescale <= 4'h0; // RQ1
            end else begin
                t1_prescale <= t1_prescale + 4'h1;
            end
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            timer1_count <= 8'h00;
        end else if (timer1_wr) begin
            timer1_count <= file_wdata;
        end else if (t1_match) begin
            timer1_count <= 8'h00; // RQ5
        end else if (t1_step) begin
            timer1_count <= timer1_count + 8'h01; // RQ3
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            timer1_period <= 8'hFF;
        end else if (period_wr) begin
            timer1_period <= file_wdata;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            timer1_match_flag <= 1'b0;
        end else if (t1_match) begin
            timer1_match_flag <= 1'b1; // RQ5
        end else if (timer1_flag_clr) begin
            timer1_match_flag <= 1'b0;
        end
    end

    // Requests lag their flag by one cycle so the outputs stay registered
    always @(posedge clk) begin
        if (sys_rst) begin
            timer0_irq <= 1'b0;
            timer1_irq <= 1'b0;
        end else begin
            timer0_irq <= timer0_overflow_flag && interrupt_enable_mask[`INTERRUPT_ENABLE_MASK_TIMER0_BIT]; // RQ23
            timer1_irq <= timer1_match_flag && interrupt_enable_mask[`INTERRUPT_ENABLE_MASK_TIMER1_BIT]; // RQ23
        end
    end
endmodule

// ==== timer_unit_sva.sv ====
// Port-level assertions for the timer, watchdog and prescaler unit
`timescale 1ns/1ns
module timer_unit_sva #(
    parameter WDT_TICKS = 8
) (
    input wire clk,
    input wire sys_rst,
    input wire timer0_wr,
    input wire timer1_wr,
    input wire timer0_flag_clr,
    input wire watchdog_clear_instr,
    input wire [7:0] timer0_count,
    input wire [7:0] timer1_count,
    input wire [7:0] timer1_period,
    input wire timer0_overflow_flag,
    input wire timer1_match_flag,
    input wire timer0_irq,
    input wire timer1_irq,
    input wire watchdog_reset,
    input wire timeout_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_t0_load;
        timer0_wr ##1 !timer0_wr;
    endsequence
    sequence s_t1_top;
        $past(timer1_count) == $past(timer1_period) && $changed(timer1_count) && !$past(timer1_wr);
    endsequence
    // Window is six edges: two ticks may land up to eight edges after the write
    property p_t0_inhibit;
        s_t0_load |=> ($stable(timer0_count) || $past(timer0_wr))[*6];
    endproperty
    a_t0_inhibit: assert property (p_t0_inhibit)
        else $error("timer0 counted during write inhibit");
    property p_t1_wrap;
        s_t1_top |-> timer1_count == 8'h00 && timer1_match_flag;
    endproperty
    a_t1_wrap: assert property (p_t1_wrap)
        else $error("timer1 did not wrap with flag at period");
    property p_t1_step;
        $changed(timer1_count) && !$past(timer1_wr)
            |-> timer1_count == $past(timer1_count) + 8'h01 || timer1_count == 8'h00;
    endproperty
    a_t1_step: assert property (p_t1_step)
        else $error("timer1 moved by other than one");
    property p_t0_wrap_flag;
        $past(timer0_count) == 8'hFF && timer0_count == 8'h00 && !$past(timer0_wr) |-> timer0_overflow_flag;
    endproperty
    a_t0_wrap_flag: assert property (p_t0_wrap_flag)
        else $error("timer0 overflow without flag");
    property p_t0_sticky;
        timer0_overflow_flag && !timer0_flag_clr |=> timer0_overflow_flag;
    endproperty
    a_t0_sticky: assert property (p_t0_sticky)
        else $error("timer0 flag dropped without clear");
    property p_irq0;
        timer0_irq |-> $past(timer0_overflow_flag);
    endproperty
    a_irq0: assert property (p_irq0)
        else $error("timer0 request without flag");
    property p_irq1;
        timer1_irq |-> $past(timer1_match_flag);
    endproperty
    a_irq1: assert property (p_irq1)
        else $error("timer1 request without flag");
    property p_wdt_status;
        $rose(watchdog_reset) |-> ##[0:1] !timeout_status;
    endproperty
    a_wdt_status: assert property (p_wdt_status)
        else $error("time-out status not cleared");
    property p_wdt_hold;
        watchdog_reset |=> watchdog_reset;
    endproperty
    a_wdt_hold: assert property (p_wdt_hold)
        else $error("watchdog reset released early");
    property p_wdt_clear;
        watchdog_clear_instr && !watchdog_reset |=> ##1 !watchdog_reset [*6];
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("time-out right after watchdog clear");
endmodule
bind timer_wdt_prescaler_unit timer_unit_sva #(.WDT_TICKS(WDT_TICKS)) timer_unit_sva_i (.clk(clk), .sys_rst(sys_rst),
    .timer0_wr(timer0_wr), .timer1_wr(timer1_wr), .timer0_flag_clr(timer0_flag_clr),
    .watchdog_clear_instr(watchdog_clear_instr), .timer0_count(timer0_count), .timer1_count(timer1_count),
    .timer1_period(timer1_period), .timer0_overflow_flag(timer0_overflow_flag), .timer1_match_flag(timer1_match_flag),
    .timer0_irq(timer0_irq), .timer1_irq(timer1_irq), .watchdog_reset(watchdog_reset), .timeout_status(timeout_status));

// ==== timer_wdt_prescaler_unit_bench.sv ====
// Self-checking bench for the timer, watchdog and prescaler unit
`timescale 1ns/1ns
`include "timer_unit_defines.vh"
`define CHK(n_, x_, y_) begin compares++; if ((y_) !== (x_)) begin miscompares++; \
    $display("mismatch %s exp %0h got %0h", n_, x_, y_); end end
module timer_wdt_prescaler_unit_bench;
reg clk = 0, sys_rst = 1, ctrl_wr = 0, option_wr = 0, timer0_wr = 0, timer1_wr = 0, period_wr = 0, wdt_osc = 0;
reg timer0_flag_clr = 0, timer1_flag_clr = 0, watchdog_clear_instr = 0, sleep_instr = 0, osc_on = 0;
reg [5:0] ctrl_addr = 0;
reg [7:0] ctrl_wdata = 0, option_wdata = 0, file_wdata = 0, rd, v;
wire [7:0] ctrl_rdata, option_value, timer0_count, timer1_count, timer1_period;
wire timer0_overflow_flag, timer1_match_flag, timer0_irq, timer1_irq, watchdog_reset, timeout_status;
integer miscompares = 0, compares = 0, cycles = 0, g, i, e, p;
timer_wdt_prescaler_unit #(.WDT_TICKS(8)) timer_wdt_prescaler_unit_i (.clk(clk), .sys_rst(sys_rst),
    .ctrl_addr(ctrl_addr), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .option_wr(option_wr),
    .option_wdata(option_wdata), .file_wdata(file_wdata), .timer0_wr(timer0_wr), .timer1_wr(timer1_wr),
    .period_wr(period_wr), .timer0_flag_clr(timer0_flag_clr), .timer1_flag_clr(timer1_flag_clr),
    .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr), .wdt_osc(wdt_osc),
    .ctrl_rdata(ctrl_rdata), .option_value(option_value), .timer0_count(timer0_count),
    .timer1_count(timer1_count), .timer1_period(timer1_period), .timer0_overflow_flag(timer0_overflow_flag),
    .timer1_match_flag(timer1_match_flag), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
    .watchdog_reset(watchdog_reset), .timeout_status(timeout_status));
always #25 clk = ~clk;
// Slow stand-in for the RC oscillator, a rising edge every six clocks
always @(posedge clk) if (osc_on && cycles % 3 == 0) wdt_osc <= #2 ~wdt_osc;
always @(posedge wdt_osc) e = e + 1;
always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
        miscompares = miscompares + 1;
        close_out;
    end
end
function integer t1_div(input [1:0] c);
    t1_div = c == 2'd0 ? 1 : 2 << c;
endfunction
task close_out; begin
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
end endtask
task tick; begin @(posedge clk); #2; end endtask
task wc(input [5:0] a, input [7:0] d); begin ctrl_addr = a; ctrl_wdata = d; ctrl_wr = 1; tick; ctrl_wr = 0; end endtask
task rc(input [5:0] a); begin ctrl_addr = a; tick; tick; rd = ctrl_rdata; end endtask
task opt(input [7:0] d); begin option_wdata = d; option_wr = 1; tick; option_wr = 0; end endtask
// First change only aligns; the second interval is the one measured
task gap(input t1); begin
    repeat (2) begin
        g = 0;
        v = t1 ? timer1_count : timer0_count;
        while ((t1 ? timer1_count : timer0_count) === v && g < 3000) begin tick; g = g + 1; end
    end
end endtask
task wdt_run(input integer n); begin
    e = 0;
    g = 0;
    while (watchdog_reset !== 1'b1 && g < 3000) begin tick; g = g + 1; end
    `CHK("wdt edges", 1'b1, e >= n - 1 && e <= n + 1)
    tick;
    `CHK("tstat", 1'b0, timeout_status)
    sys_rst = 1;
    repeat (4) tick;
    sys_rst = 0;
end endtask
initial begin
    i = $urandom(32'h95cd);
    repeat (4) tick;
    sys_rst = 0;
    `CHK("option", 8'hBF, option_value)
    `CHK("tstat", 1'b1, timeout_status)
    rc(`ADDR_POWER_CONTROL); `CHK("power_control", 8'h31, rd)
    rc(6'h0D); `CHK("unmapped", 8'h00, rd)
    i = $urandom;
    wc(`ADDR_IRQ_ENABLE_MASK, i[7:0]); rc(`ADDR_IRQ_ENABLE_MASK); `CHK("mask", i[7:0], rd)
    wc(`ADDR_TIMER1_CONTROL, 8'hFF); rc(`ADDR_TIMER1_CONTROL); `CHK("t1ctl", 8'h07, rd)
    wc(`ADDR_IRQ_ENABLE_MASK, 8'h00);
    $display("test registers done");
    for (i = 0; i < 4; i = i + 1) begin
        file_wdata = 8'h00; timer1_wr = 1; tick; timer1_wr = 0;
        wc(`ADDR_TIMER1_CONTROL, {6'h01, i[1:0]});
        gap(1); `CHK("t1 gap", 4 * t1_div(i[1:0]), g)
    end
    wc(`ADDR_TIMER1_CONTROL, 8'h00); v = timer1_count; repeat (100) tick;
    `CHK("t1 stop", v, timer1_count)
    `CHK("t1 flag", 1'b0, timer1_match_flag)
    p = $urandom % 4 + 1;
    file_wdata = p[7:0]; period_wr = 1; tick; period_wr = 0;
    `CHK("period", p[7:0], timer1_period)
    wc(`ADDR_TIMER1_CONTROL, 8'h04);
    file_wdata = 8'h00; timer1_wr = 1; tick; timer1_wr = 0;
    g = 0;
    while (timer1_match_flag !== 1'b1 && g < 300) begin tick; g = g + 1; end
    `CHK("t1 wrap time", 1'b1, g > 4 * p && g <= 4 * p + 4)
    `CHK("t1 wrap", 8'h00, timer1_count)
    `CHK("t1 irq off", 1'b0, timer1_irq)
    wc(`ADDR_TIMER1_CONTROL, 8'h00); tick; wc(`ADDR_IRQ_ENABLE_MASK, 8'h08); tick;
    `CHK("t1 irq", 1'b1, timer1_irq)
    timer1_flag_clr = 1; tick; timer1_flag_clr = 0; tick;
    `CHK("t1 irq clr", 1'b0, timer1_irq)
    $display("test timer1 done");
    opt(8'h08); gap(0); `CHK("t0 gap", 4, g)
    watchdog_clear_instr = 1; tick; watchdog_clear_instr = 0;
    for (i = 0; i < 8; i = i + 1) begin
        opt({5'h00, i[2:0]}); gap(0); `CHK("t0 ratio", 8 << i, g)
    end
    file_wdata = 8'h10; timer0_wr = 1; tick; timer0_wr = 0;
    g = 0;
    while (timer0_count === 8'h10 && g < 2000) begin tick; g = g + 1; end
    `CHK("t0 pre clr", 1'b1, g >= 1021 && g <= 1024)
    watchdog_clear_instr = 1; tick; watchdog_clear_instr = 0;
    opt(8'h08); file_wdata = 8'hFE; timer0_wr = 1; timer0_flag_clr = 1; tick; timer0_wr = 0; timer0_flag_clr = 0;
    g = 0;
    while (timer0_count === 8'hFE && g < 100) begin tick; g = g + 1; end
    `CHK("t0 inhibit", 1'b1, g >= 9 && g <= 12)
    while (timer0_count !== 8'h00 && g < 200) begin tick; g = g + 1; end
    `CHK("t0 flag", 1'b1, timer0_overflow_flag)
    wc(`ADDR_IRQ_ENABLE_MASK, 8'h01); tick;
    `CHK("t0 irq", 1'b1, timer0_irq)
    timer0_flag_clr = 1; tick; timer0_flag_clr = 0;
    `CHK("t0 flag clr", 1'b0, timer0_overflow_flag)
    $display("test timer0 done");
    osc_on = 1;
    watchdog_clear_instr = 1; tick; watchdog_clear_instr = 0; opt(8'h00);
    wdt_run(8);
    watchdog_clear_instr = 1; tick; watchdog_clear_instr = 0; opt(8'h00);
    repeat (20) begin repeat (30) tick; watchdog_clear_instr = 1; tick; watchdog_clear_instr = 0; end
    `CHK("wdt kept", 1'b0, watchdog_reset)
    wc(`ADDR_POWER_CONTROL, 8'h01); repeat (300) tick;
    `CHK("wdt off", 1'b0, watchdog_reset)
    wc(`ADDR_POWER_CONTROL, 8'h21);
    p = $urandom % 3;
    watchdog_clear_instr = 1; tick; watchdog_clear_instr = 0;
    opt({5'h01, p[2:0]}); sleep_instr = 1; tick; sleep_instr = 0;
    wdt_run(8 << p);
    $display("test watchdog done");
    close_out;
end
endmodule
